//--- hw/sic_top.sv
`timescale 1ns/1ps
`default_nettype none

module sic_top
  import sic_pkg::*;
(
  input  wire logic            ref_clk_in,
  input  wire logic            sys_rst_in,
  // Pin function: high selects three separate requests
  input  wire logic            pin_sep_mode_in,
  input  wire logic [2:0]      encoded_level_inputs_n_in,
  input  wire logic [5:0]      int_req_in,
  input  wire logic [12:0]     interrupt_mask_reg_in,
  // Source control register write and read-back
  input  wire logic            icr_wr_in,
  input  wire logic [3:0]      icr_wr_idx_in,
  input  wire logic [7:0]      icr_wr_data_in,
  input  wire logic [3:0]      icr_rd_idx_in,
  input  wire logic [7:0]      watchdog_vector_reg_in,
  input  wire logic [7:0]      uart1_vector_in,
  input  wire logic [7:0]      uart2_vector_in,
  // Acknowledge request from the core
  input  wire logic            ack_req_in,
  input  wire logic [2:0]      ack_level_in,
  // External acknowledge cycle response pins
  input  wire logic            ext_ta_n_in,
  input  wire logic            ext_tea_n_in,
  input  wire logic [7:0]      ext_data_in,
  output logic [7:0]           icr_rd_data_out,
  output logic [12:0]          pending_reg_out,
  output logic [2:0]           irq_level_out,
  output sic_ack_type          ack_out,
  output logic [5:0]           periph_ack_out,
  output sic_ext_bus_type      ext_bus_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Encoded pins are active low: level is seven minus the pin value
  function automatic logic [2:0] lvl_decode(input logic [2:0] pins);
    lvl_decode = SIC_LVL_MAX - pins;
  endfunction : lvl_decode

  // Apply the fixed and forced fields of each source on a write
  function automatic sic_icr_type icr_filter(input logic [3:0] idx,
                                             input logic [7:0] data);
    sic_icr_type r;
    sic_icr_type rst;
    r      = sic_icr_type'(data);
    rst    = sic_icr_type'(SIC_ICR_RST[idx]);
    r.rsvd = '0;
    if (idx < 4'(SIC_NUM_EXT)) begin
      r.level = rst.level;
    end else if (idx == 4'(SIC_IDX_WDOG)) begin
      r.level = SIC_WDOG_LEVEL;
      r.autovector_select  = 1'b0;
    end else if (idx <= 4'(SIC_IDX_TWB)) begin
      r.autovector_select  = 1'b1;
    end
    icr_filter = r;
  endfunction : icr_filter

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] pin_s3;
  logic [1:0] resp_s1;
  logic [1:0] resp_s2;
  logic [7:0] data_s1;
  logic [7:0] data_s2;

  // Two flops per pin; third stage only compares successive samples
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_s1  <= SIC_PINS_IDLE;
      pin_s2  <= SIC_PINS_IDLE;
      pin_s3  <= SIC_PINS_IDLE;
      resp_s1 <= 2'h3;
      resp_s2 <= 2'h3;
      data_s1 <= SIC_DATA_RST;
      data_s2 <= SIC_DATA_RST;
    end else begin
      pin_s1  <= encoded_level_inputs_n_in;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      resp_s1 <= {ext_tea_n_in, ext_ta_n_in};
      resp_s2 <= resp_s1;
      data_s1 <= ext_data_in;
      data_s2 <= data_s1;
    end
  end

  logic [2:0] lvl_now;
  logic [2:0] lvl_prev;
  logic [2:0] sep_valid;
  logic       ta_seen;
  logic       tea_seen;

  // Separate requests need two low samples in a row
  assign lvl_now   = lvl_decode(pin_s2);
  assign lvl_prev  = lvl_decode(pin_s3);
  assign sep_valid = ~pin_s2 & ~pin_s3;
  assign ta_seen   = ~resp_s2[0];
  assign tea_seen  = ~resp_s2[1];

  ////////////////////////////////////////////////////////////////////////////
  // Source control registers
  sic_icr_type source_control_reg      [0:12];
  sic_icr_type next_icr [0:12];
  logic [7:0]  next_icr_rd;

  // Writes outside the source range are dropped
  always_comb begin
    for (int i = 0; i < SIC_NUM_SRC; i++) begin
      next_icr[i] = source_control_reg[i];
    end
    if (icr_wr_in && (icr_wr_idx_in < 4'(SIC_NUM_SRC))) begin
      next_icr[icr_wr_idx_in] = icr_filter(icr_wr_idx_in, icr_wr_data_in);
    end
    next_icr_rd = 8'h00;
    if (icr_rd_idx_in < 4'(SIC_NUM_SRC)) begin
      next_icr_rd = source_control_reg[icr_rd_idx_in];
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < SIC_NUM_SRC; i++) begin
        source_control_reg[i] <= sic_icr_type'(SIC_ICR_RST[i]);
      end
      icr_rd_data_out <= 8'h00;
    end else begin
      for (int i = 0; i < SIC_NUM_SRC; i++) begin
        source_control_reg[i] <= next_icr[i];
      end
      icr_rd_data_out <= next_icr_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending bits and presented level
  logic [12:0] pend;
  logic [12:0] next_pend;
  logic [2:0]  cur_lvl;
  logic [2:0]  next_cur_lvl;
  logic [2:0]  next_irq_lvl;
  logic        ack_ext;

  always_comb begin
    next_pend    = pend;
    next_cur_lvl = cur_lvl;
    // Internal requests are already in this clock domain
    next_pend[12:7] = int_req_in;
    if (pin_sep_mode_in) begin
      // Pending tracks the filtered pin; the requester holds it
      next_pend[6:0]          = 7'h00;
      next_pend[SIC_SEP_IDX0] = sep_valid[0];
      next_pend[SIC_SEP_IDX1] = sep_valid[1];
      next_pend[SIC_SEP_IDX2] = sep_valid[2];
      next_cur_lvl            = SIC_LVL_NONE;
    end else begin
      if (lvl_now == lvl_prev) begin
        next_cur_lvl = lvl_now;
        // Levels above the one now driven have dropped in priority
        for (int i = 0; i < SIC_NUM_EXT; i++) begin
          if (3'(i + 1) > lvl_now) begin
            next_pend[i] = 1'b0;
          end
        end
      end
      // Completed acknowledge of an external source at a level no longer driven clears it
      if (ack_out.done && ack_ext && (ack_out.level != cur_lvl) &&
          (ack_out.level != SIC_LVL_NONE)) begin
        next_pend[ack_out.level - 3'h1] = 1'b0;
      end
      // Set placed last so a new level wins over any clear
      if ((lvl_now == lvl_prev) && (lvl_now != SIC_LVL_NONE)) begin
        next_pend[lvl_now - 3'h1] = 1'b1;
      end
    end
    // Highest level among unmasked pending sources
    next_irq_lvl = SIC_LVL_NONE;
    for (int i = 0; i < SIC_NUM_SRC; i++) begin
      if (pend[i] && !interrupt_mask_reg_in[i] && (source_control_reg[i].level > next_irq_lvl)) begin
        next_irq_lvl = source_control_reg[i].level;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend          <= 13'h0000;
      cur_lvl       <= SIC_LVL_NONE;
      irq_level_out <= SIC_LVL_NONE;
    end else begin
      pend          <= next_pend;
      cur_lvl       <= next_cur_lvl;
      irq_level_out <= next_irq_lvl;
    end
  end

  assign pending_reg_out = pend;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge source selection
  logic       pick_found;
  logic [3:0] pick_idx;
  logic [1:0] pick_prio;

  // Ties cannot happen with unique settings; lowest index wins then
  always_comb begin
    pick_found = 1'b0;
    pick_idx   = 4'h0;
    pick_prio  = 2'h0;
    for (int i = 0; i < SIC_NUM_SRC; i++) begin
      if (pend[i] && !interrupt_mask_reg_in[i] && (source_control_reg[i].level == ack_level_in) &&
          (!pick_found || (source_control_reg[i].prio > pick_prio))) begin
        pick_found = 1'b1;
        pick_idx   = 4'(i);
        pick_prio  = source_control_reg[i].prio;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge sequencer
  sic_state_type   state;
  sic_state_type   next_state;
  sic_ack_type     next_ack;
  sic_ext_bus_type next_bus;
  logic [5:0]      next_periph;
  logic            next_ack_ext;
  sic_icr_type     pick_icr;
  logic [7:0]      autovec;

  assign pick_icr = source_control_reg[pick_idx];
  assign autovec  = SIC_AUTOVEC_BASE + {5'h00, ack_level_in};

  always_comb begin
    next_state       = state;
    next_ack         = ack_out;
    next_ack.done    = 1'b0;
    next_bus         = ext_bus_out;
    next_bus.start   = 1'b0;
    next_periph      = 6'h00;
    next_ack_ext     = ack_ext;
    case (state)
      SIC_ST_IDLE: begin
        // Requests while a bus cycle runs are ignored
        if (ack_req_in) begin
          next_ack.level = ack_level_in;
          next_ack_ext   = pick_found && (pick_idx < 4'(SIC_NUM_EXT));
          if (!pick_found) begin
            next_ack.done   = 1'b1;
            next_ack.kind   = SIC_ANS_SPURIOUS;
            next_ack.vector = SIC_SPURIOUS_VEC;
          end else if (pick_idx == 4'(SIC_IDX_WDOG)) begin
            next_ack.done   = 1'b1;
            next_ack.kind   = SIC_ANS_WDOG;
            next_ack.vector = watchdog_vector_reg_in;
            next_periph[0]  = 1'b1;
          end else if (pick_idx > 4'(SIC_IDX_WDOG)) begin
            // Internal acknowledge always runs; vector depends on autovector_select
            next_ack.done = 1'b1;
            next_periph[3'(pick_idx - 4'(SIC_IDX_WDOG))] = 1'b1;
            if (pick_icr.autovector_select) begin
              next_ack.kind   = SIC_ANS_AUTOVEC;
              next_ack.vector = autovec;
            end else begin
              next_ack.kind   = SIC_ANS_PERIPH;
              next_ack.vector = (pick_idx == 4'(SIC_IDX_URT1)) ?
                                uart1_vector_in : uart2_vector_in;
            end
          end else if (pick_icr.autovector_select) begin
            next_ack.done   = 1'b1;
            next_ack.kind   = SIC_ANS_AUTOVEC;
            next_ack.vector = autovec;
          end else begin
            // External cycle: all-ones type, address all-ones above the level and zeros below it
            next_bus.tt           = SIC_TT_ACK;
            next_bus.addr         = {SIC_ADDR_HI_ACK, ack_level_in, SIC_ADDR_LO_ACK};
            next_bus.start        = 1'b1;
            next_bus.space_marker = 1'b1;
            next_state            = SIC_ST_START;
          end
        end
      end
      SIC_ST_START: begin
        // Marker drops together with the start strobe
        next_bus.space_marker = 1'b0;
        next_state            = SIC_ST_WAIT;
      end
      SIC_ST_WAIT: begin
        // Error response maps to spurious; data sampled after two flops
        if (tea_seen || ta_seen) begin
          next_ack.done   = 1'b1;
          next_ack.kind   = tea_seen ? SIC_ANS_SPURIOUS : SIC_ANS_EXTERNAL;
          next_ack.vector = tea_seen ? SIC_SPURIOUS_VEC : data_s2;
          next_bus        = '0;
          next_state      = SIC_ST_IDLE;
        end
      end
      default: begin
        next_bus   = '0;
        next_state = SIC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state          <= SIC_ST_IDLE;
      ack_out        <= '0;
      ext_bus_out    <= '0;
      periph_ack_out <= 6'h00;
      ack_ext        <= 1'b0;
    end else begin
      state          <= next_state;
      ack_out        <= next_ack;
      ext_bus_out    <= next_bus;
      periph_ack_out <= next_periph;
      ack_ext        <= next_ack_ext;
    end
  end

endmodule : sic_top

`default_nettype wire

//--- pkg/sic_pkg.sv
// Shared constants and carriers for the system interrupt controller
package sic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Source numbering: seven external levels, then the internal sources
  localparam int SIC_NUM_SRC  = 13;
  localparam int SIC_NUM_EXT  = 7;
  localparam int SIC_NUM_INT  = 6;
  localparam int SIC_IDX_WDOG = 7;
  localparam int SIC_IDX_TMR1 = 8;
  localparam int SIC_IDX_TMR2 = 9;
  localparam int SIC_IDX_TWB  = 10;
  localparam int SIC_IDX_URT1 = 11;
  localparam int SIC_IDX_URT2 = 12;

  // Separate-request mode: pin 0, 1, 2 feed sources at levels 1, 4, 7
  localparam int SIC_SEP_IDX0 = 0;
  localparam int SIC_SEP_IDX1 = 3;
  localparam int SIC_SEP_IDX2 = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Source control register layout: autovector_select, reserved, level, priority
  typedef struct packed {
    logic       autovector_select;
    logic [1:0] rsvd;
    logic [2:0] level;
    logic [1:0] prio;
  } sic_icr_type;

  localparam logic [7:0] SIC_ICR_RST [0:12] = '{
    8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
    8'h1c, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};

  localparam logic [2:0] SIC_WDOG_LEVEL = 3'h7;
  localparam logic [2:0] SIC_LVL_NONE   = 3'h0;
  localparam logic [2:0] SIC_LVL_MAX    = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Vectors and acknowledge bus cycle values
  localparam logic [7:0]  SIC_SPURIOUS_VEC = 8'h18;
  localparam logic [7:0]  SIC_AUTOVEC_BASE = 8'h18;
  localparam logic [1:0]  SIC_TT_ACK       = 2'h3;
  localparam logic [22:0] SIC_ADDR_HI_ACK  = 23'h7fffff;
  localparam logic [1:0]  SIC_ADDR_LO_ACK  = 2'h0;

  // Reset values of the synchroniser chains (pins idle high)
  localparam logic [2:0] SIC_PINS_IDLE = 3'h7;
  localparam logic [7:0] SIC_DATA_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef enum logic [2:0] {
    SIC_ANS_SPURIOUS,
    SIC_ANS_AUTOVEC,
    SIC_ANS_WDOG,
    SIC_ANS_PERIPH,
    SIC_ANS_EXTERNAL
  } sic_answer_type;

  typedef struct packed {
    logic           done;
    sic_answer_type kind;
    logic [7:0]     vector;
    logic [2:0]     level;
  } sic_ack_type;

  typedef struct packed {
    logic [1:0]  tt;
    logic [27:0] addr;
    logic        space_marker;
    logic        start;
  } sic_ext_bus_type;

  typedef enum {
    SIC_ST_IDLE,
    SIC_ST_START,
    SIC_ST_WAIT
  } sic_state_type;

endpackage : sic_pkg

//--- bench/sic_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module sic_top_chk
  import sic_pkg::*;
(
  input wire logic            ref_clk_in,
  input wire logic            sys_rst_in,
  input wire logic [5:0]      int_req_in,
  input wire logic [12:0]     interrupt_mask_reg_in,
  input wire logic            ack_req_in,
  input wire logic [2:0]      ack_level_in,
  input wire logic [12:0]     pending_reg_out,
  input wire logic [2:0]      irq_level_out,
  input wire sic_ack_type     ack_out,
  input wire logic [5:0]      periph_ack_out,
  input wire sic_ext_bus_type ext_bus_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////
  // Acknowledge bus cycle: opening beat, then marker drops with start
  sequence s_ext_open;
    ext_bus_out.start && ext_bus_out.space_marker && ext_bus_out.tt == SIC_TT_ACK;
  endsequence
  sequence s_ext_next;
    !ext_bus_out.start && !ext_bus_out.space_marker && ext_bus_out.tt == SIC_TT_ACK;
  endsequence

  property p_int_pend;
    !$past(sys_rst_in) |-> pending_reg_out[12:7] == $past(int_req_in);
  endproperty
  property p_irq_any;
    irq_level_out != SIC_LVL_NONE |-> $past(|(pending_reg_out & ~interrupt_mask_reg_in));
  endproperty
  // External sources never sit at level zero, so they must raise the output
  property p_irq_ext;
    $past(|(pending_reg_out[6:0] & ~interrupt_mask_reg_in[6:0])) |-> irq_level_out != 3'h0;
  endproperty
  property p_spur_vec;
    ack_out.done && ack_out.kind == SIC_ANS_SPURIOUS |-> ack_out.vector == 8'h18;
  endproperty
  property p_auto_vec;
    ack_out.done && ack_out.kind == SIC_ANS_AUTOVEC
      |-> ack_out.vector == SIC_AUTOVEC_BASE + {5'h00, ack_out.level};
  endproperty
  property p_ext_frame;
    ext_bus_out.start
      |-> s_ext_open ##0 ext_bus_out.addr == {23'h7fffff, $past(ack_level_in), 2'h0};
  endproperty
  property p_marker;
    s_ext_open |=> s_ext_next;
  endproperty
  property p_periph_done;
    |periph_ack_out |-> ack_out.done && ack_out.kind inside
      {SIC_ANS_PERIPH, SIC_ANS_AUTOVEC, SIC_ANS_WDOG};
  endproperty
  // Idle request is answered or opens a bus cycle on the next edge
  property p_ack_answer;
    ack_req_in && ext_bus_out.tt == 2'h0 && !ack_out.done |=> ack_out.done || ext_bus_out.start;
  endproperty

  a_int_pend: assert property (p_int_pend) else $error("pending lags request");
  a_irq_any: assert property (p_irq_any) else $error("level without source");
  a_irq_ext: assert property (p_irq_ext) else $error("external not shown");
  a_spur_vec: assert property (p_spur_vec) else $error("bad spurious vector");
  a_auto_vec: assert property (p_auto_vec) else $error("bad autovector");
  a_ext_frame: assert property (p_ext_frame) else $error("bad ack address");
  a_marker: assert property (p_marker) else $error("marker not with start");
  a_periph_done: assert property (p_periph_done) else $error("stray periph ack");
  a_ack_answer: assert property (p_ack_answer) else $error("ack not answered");
endmodule : sic_top_chk

bind sic_top sic_top_chk sic_top_chk_i (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .int_req_in(int_req_in),
  .interrupt_mask_reg_in(interrupt_mask_reg_in),
  .ack_req_in(ack_req_in),
  .ack_level_in(ack_level_in),
  .pending_reg_out(pending_reg_out),
  .irq_level_out(irq_level_out),
  .ack_out(ack_out),
  .periph_ack_out(periph_ack_out),
  .ext_bus_out(ext_bus_out)
);

`default_nettype wire

//--- bench/sic_ext_dev.sv
`timescale 1ns/1ps
`default_nettype none

module sic_ext_dev
  import sic_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire sic_ext_bus_type bus_in,
  input  wire logic [3:0]      wait_in,
  input  wire logic            err_in,
  input  wire logic [7:0]      vec_in,
  output logic                 ta_n_out,
  output logic                 tea_n_out,
  output logic [7:0]           data_out
);
  logic [4:0] cnt;

  // Vector goes out at cycle start, answer after the wait: data settles early
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 5'h00;
      ta_n_out <= 1'b1;
      tea_n_out <= 1'b1;
      data_out <= 8'h00;
    end else if (bus_in.start) begin
      cnt <= {1'b0, wait_in} + 5'h02;
      data_out <= vec_in;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h01) begin
        ta_n_out <= err_in;
        tea_n_out <= !err_in;
      end
    end else if (bus_in.tt == 2'h0) begin
      // Released: responses idle, data toggles between the old vector and its complement
      ta_n_out <= 1'b1;
      tea_n_out <= 1'b1;
      data_out <= ~data_out;
    end
  end
endmodule : sic_ext_dev

`default_nettype wire

//--- bench/sic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sic_top_tb
  import sic_pkg::*;
;
  logic            clk, rst, sep, wr_en, ack_req, ta_n, tea_n, err;
  logic [2:0]      pins, ack_lvl, irq;
  logic [3:0]      wr_idx, rd_idx, dly;
  logic [5:0]      req, pack;
  logic [7:0]      wr_data, rd_data, ext_data, ev;
  logic [12:0]     mask, pend;
  sic_ack_type     ack;
  sic_ext_bus_type bus;
  int              fails, checks;

  always #4 clk = ~clk;

  sic_top sic_top_i (.ref_clk_in(clk), .sys_rst_in(rst), .pin_sep_mode_in(sep),
    .encoded_level_inputs_n_in(pins), .int_req_in(req), .interrupt_mask_reg_in(mask),
    .icr_wr_in(wr_en), .icr_wr_idx_in(wr_idx), .icr_wr_data_in(wr_data),
    .icr_rd_idx_in(rd_idx), .watchdog_vector_reg_in(8'h0f), .uart1_vector_in(8'h41),
    .uart2_vector_in(8'h42), .ack_req_in(ack_req), .ack_level_in(ack_lvl),
    .ext_ta_n_in(ta_n), .ext_tea_n_in(tea_n), .ext_data_in(ext_data),
    .icr_rd_data_out(rd_data), .pending_reg_out(pend), .irq_level_out(irq),
    .ack_out(ack), .periph_ack_out(pack), .ext_bus_out(bus));

  sic_ext_dev sic_ext_dev_i (.clk_in(clk), .rst_in(rst), .bus_in(bus), .wait_in(dly),
    .err_in(err), .vec_in(ev), .ta_n_out(ta_n), .tea_n_out(tea_n), .data_out(ext_data));

  ////////////////////////////////////////
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic icr_write(input logic [3:0] i, input logic [7:0] d);
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    tick();
    wr_en = 1'b0;
    // Let an edge pass so back-to-back writes never re-raise the strobe in one step
    tick();
  endtask : icr_write

  task automatic icr_read(input logic [3:0] i, input logic [7:0] e);
    rd_idx = i;
    tick(2);
    chk(13'(rd_data), 13'(e));
  endtask : icr_read

  // One-cycle request, then a bounded wait for the answer pulse
  task automatic do_ack(input logic [2:0] l, input sic_answer_type k, input logic [7:0] v,
                        input logic [5:0] p);
    int n = 0;
    ack_req = 1'b1;
    ack_lvl = l;
    tick();
    ack_req = 1'b0;
    // Done can already stand right after the request edge; look before ticking on
    while (ack.done !== 1'b1 && n < 30) begin
      tick();
      n++;
    end
    chk(13'(ack.done), 13'h0001);
    chk(13'(ack.kind), 13'(k));
    chk(13'(ack.vector), 13'(v));
    chk(13'(pack), 13'(p));
    tick();
  endtask : do_ack

  // Fixed fields win over written ones
  function automatic logic [7:0] exp_icr(input int i, input logic [7:0] d);
    if (i < 7) return {d[7], 2'h0, 3'(i + 1), d[1:0]};
    if (i == 7) return {3'h0, 3'h7, d[1:0]};
    if (i < 11) return {3'h4, d[4:0]};
    return {d[7], 2'h0, d[4:0]};
  endfunction : exp_icr

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////
  // Whole run is under a thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    {clk, wr_en, ack_req, err, fails, checks} = '0;
    rst = 1'b1;
    sep = 1'b1;
    pins = 3'h7;
    {ack_lvl, wr_idx, rd_idx, dly, req, wr_data, ev} = '0;
    mask = 13'h1fff;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 13; i++) icr_read(4'(i), SIC_ICR_RST[i]);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 14; i++) begin
        icr_write(4'(i), j ? 8'h00 : 8'hff);
        icr_read(4'(i), (i < 13) ? exp_icr(i, j ? 8'h00 : 8'hff) : 8'h00);
      end
    end
    icr_write(4'h7, 8'h02);
    icr_write(4'h8, 8'h15);
    icr_write(4'hb, 8'h16);
    icr_write(4'h6, 8'h03);
    icr_read(4'h8, 8'h95);
    // Internal sources, masked then open
    req = 6'h12;
    tick(2);
    chk(pend, 13'h0900);
    chk(13'(irq), 13'h0000);
    mask = 13'h0000;
    tick(2);
    chk(13'(irq), 13'h0005);
    do_ack(3'h5, SIC_ANS_PERIPH, 8'h41, 6'h10);
    mask = 13'h0800;
    tick();
    do_ack(3'h5, SIC_ANS_AUTOVEC, 8'h1d, 6'h02);
    req = 6'h01;
    tick(3);
    chk(13'(irq), 13'h0007);
    do_ack(3'h7, SIC_ANS_WDOG, 8'h0f, 6'h01);
    req = 6'h00;
    tick(2);
    do_ack(3'h2, SIC_ANS_SPURIOUS, 8'h18, 6'h00);
    // Separate requests: glitch ignored, held pin taken
    pins = 3'h3;
    tick();
    pins = 3'h7;
    tick(6);
    chk(pend, 13'h0000);
    pins = 3'h3;
    tick(5);
    chk(pend, 13'h0040);
    ev = 8'hc5;
    dly = 4'h3;
    do_ack(3'h7, SIC_ANS_EXTERNAL, 8'hc5, 6'h00);
    err = 1'b1;
    do_ack(3'h7, SIC_ANS_SPURIOUS, 8'h18, 6'h00);
    err = 1'b0;
    pins = 3'h7;
    tick(6);
    chk(pend, 13'h0000);
    // Encoded levels 3, then 6, then 1
    sep = 1'b0;
    tick();
    pins = 3'h4;
    tick(5);
    chk(pend, 13'h0004);
    pins = 3'h1;
    tick(5);
    chk(pend, 13'h0024);
    ev = 8'h9a;
    dly = 4'h0;
    do_ack(3'h3, SIC_ANS_EXTERNAL, 8'h9a, 6'h00);
    tick();
    chk(pend, 13'h0020);
    pins = 3'h6;
    tick(5);
    chk(pend, 13'h0001);
    do_ack(3'h6, SIC_ANS_SPURIOUS, 8'h18, 6'h00);
    // Autovectored external level: no bus cycle, driven level stays pending
    icr_write(4'h0, 8'h80);
    do_ack(3'h1, SIC_ANS_AUTOVEC, 8'h19, 6'h00);
    chk(pend, 13'h0001);
    finish_test();
  end
endmodule : sic_top_tb

`default_nettype wire
